// [verilog/fcd_datapath.sv]
// cycle sequencer and datapath of the floating unit
`timescale 1ns/100ps
`default_nettype none
// -------------------------------------------------------------------
// What this block does
// - always exactly one operating cycle while busy
// - 1200 ns cycles (twelve 100 ns phases), three states, four phases
// - fetch loads instruction latch and operand address
// - indirect addressing stays in fetch
// - operand load reads one, two, three words
// - non-memory instructions skip operand load
// - add/sub right-shifts smaller-exponent mantissa
// - multiply/divide compute result exponent in scale
// - integer negatives become sign and magnitude
// - compute cycle performs operation, may extend
// - justify normalizes, 150 ns per shift
// - write stores words, 1.2 us each
// - memory input through 36-bit word buffer
// - latch instruction bits 6 to 17
// - 17-bit operand address register
// - 36-bit ALU result bus to registers
// - 18-bit exponents, single precision sign-extended
// - 35-bit accumulator mantissa with sign bit
// - 36-bit extension catches shifted bits, rounds
// - operand mantissa only shifts right
// - shift counter counts shifts, caps 35; words have their own counter
// - software-loaded 15-bit trap vector base
// -------------------------------------------------------------------
module fcd_datapath (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic i_START,
   input wire logic i_NONMEM,
   input wire logic [1:0] i_FMT,
   input wire logic [2:0] i_OP,
   input wire logic i_ROUND,
   input wire logic [17:0] i_MEM_HALF,
   input wire logic i_MEM_VALID,
   input wire logic i_TRAP_LOAD,
   input wire logic [14:0] i_TRAP_DATA,
   output logic o_MEM_REQ,
   output logic o_MEM_WRITE,
   output logic [16:0] o_MEM_ADDR,
   output logic [17:0] o_MEM_WDATA,
   output logic [2:0] o_CYCLE,
   output logic o_BUSY,
   output logic o_ERROR,
   output logic [14:0] o_TRAP_VECTOR,
   output logic [11:0] o_INSTR,
   output logic [17:0] o_ACC_EXP,
   output logic o_ACC_SIGN,
   output logic [34:0] o_ACC_MANT
);
   // -----------------------------------------------------------------
   // state and registers
   // -----------------------------------------------------------------
   fcd_pkg::fcd_cycle_t cycle_reg, cycle_next;
   logic [1:0] tick_reg;
   logic [3:0] phase_reg;
   logic [35:0] memory_word_buffer_reg;
   logic half_sel_reg;
   logic [11:0] instruction_latch_reg;
   logic [16:0] operand_address_reg;
   logic [17:0] acc_exponent_counter_reg;
   logic [17:0] operand_exponent_reg;
   logic [34:0] acc_mantissa_reg;
   logic acc_sign_reg;
   logic [34:0] operand_mantissa_reg;
   logic operand_sign_reg;
   logic [35:0] mantissa_extension_reg;
   logic [5:0] shift_count_reg;
   logic [1:0] word_count_reg;
   logic [14:0] trap_vector_base_reg;
   logic indirect_reg;
   logic error_reg;
   logic [1:0] fmt_reg;
   logic [2:0] op_reg;
   logic nonmem_reg;
   logic round_reg;
   logic [17:0] mem_half_s1, mem_half_s2;
   logic mem_valid_s1, mem_valid_s2;

   // -----------------------------------------------------------------
   // timing: phase enable and end of basic cycle
   // -----------------------------------------------------------------
   // a phase lasts two clocks (100 ns), the nearest length not shorter
   wire phase_en = (tick_reg == 2'(fcd_pkg::PHASE_CLKS - 1));
   wire cycle_end = phase_en &&
      (phase_reg == 4'(fcd_pkg::PHASES_PER_CYCLE - 1));
   // shift on every third clock of the cycle; 24 clocks hold whole steps
   wire shift_en = ({phase_reg, tick_reg[0]} %
      5'(fcd_pkg::NORM_SHIFT_CLKS)) == 5'(fcd_pkg::NORM_SHIFT_CLKS - 1);

   // -----------------------------------------------------------------
   // ALU and decoding
   // -----------------------------------------------------------------
   wire [35:0] alu_a = {1'b0, acc_mantissa_reg};
   wire [35:0] alu_b = {1'b0, operand_mantissa_reg};
   wire eff_sub = (op_reg == fcd_pkg::OP_SUB) ^ (acc_sign_reg ^
      operand_sign_reg);
   wire [35:0] alu_sum = alu_a + alu_b;
   wire [35:0] alu_diff = alu_a - alu_b;
   wire [35:0] alu_bus = (op_reg == fcd_pkg::OP_LOAD) ? alu_b :
      (op_reg == fcd_pkg::OP_NEG) ? alu_a :
      (op_reg == fcd_pkg::OP_CLR) ? 36'h000000000 :
      eff_sub ? alu_diff : alu_sum;
   wire [17:0] exp_diff = acc_exponent_counter_reg - operand_exponent_reg;
   wire exp_acc_small = exp_diff[17];
   wire [17:0] exp_mag = exp_acc_small ? 18'(-exp_diff) : exp_diff;
   wire exp_too_far = (exp_mag > 18'(fcd_pkg::MAX_SHIFT));
   wire is_float = fmt_reg[1];
   wire is_addsub = (op_reg == fcd_pkg::OP_ADD) ||
      (op_reg == fcd_pkg::OP_SUB);
   wire is_muldiv = (op_reg == fcd_pkg::OP_MUL) ||
      (op_reg == fcd_pkg::OP_DIV);
   wire [1:0] need_words = fcd_pkg::words_of(fmt_reg);
   wire aligned = !is_float || !is_addsub || (exp_diff == 18'h00000)
      || (shift_count_reg == fcd_pkg::MAX_SHIFT);
   wire normalized = !is_float || acc_mantissa_reg[34] ||
      (acc_mantissa_reg == 35'h000000000) ||
      (shift_count_reg == fcd_pkg::MAX_SHIFT);
   wire muldiv_done = !is_muldiv || (shift_count_reg ==
      fcd_pkg::MAX_SHIFT);
   wire word_in = mem_valid_s2 && half_sel_reg;
   wire [35:0] mem_word = {memory_word_buffer_reg[35:18], mem_half_s2};
   wire div_zero = (op_reg == fcd_pkg::OP_DIV) &&
      (operand_mantissa_reg == 35'h000000000);
   wire exp_ovf = acc_exponent_counter_reg[17] !=
      acc_exponent_counter_reg[16];
   wire sp_exp_neg = mem_word[fcd_pkg::SP_EXP_MSB];

   // -----------------------------------------------------------------
   // next cycle selection
   // -----------------------------------------------------------------
   always_comb begin
      cycle_next = cycle_reg;
      unique case (cycle_reg)
         fcd_pkg::CY_IDLE: if (i_START) cycle_next = fcd_pkg::CY_FETCH;
         fcd_pkg::CY_FETCH: begin
            if (word_in && (indirect_reg || !mem_word[17])) begin
               cycle_next = nonmem_reg ? fcd_pkg::CY_SCALE :
                  fcd_pkg::CY_OPAND;
            end
         end
         fcd_pkg::CY_OPAND: begin
            if (word_in && (word_count_reg == need_words - 2'h1)) begin
               cycle_next = fcd_pkg::CY_SCALE;
            end
         end
         fcd_pkg::CY_SCALE: begin
            if (cycle_end && aligned) cycle_next = fcd_pkg::CY_COMPUTE;
         end
         fcd_pkg::CY_COMPUTE: begin
            if (div_zero) cycle_next = fcd_pkg::CY_INTR;
            else if (cycle_end && muldiv_done)
               cycle_next = fcd_pkg::CY_JUSTIFY;
         end
         fcd_pkg::CY_JUSTIFY: begin
            if (cycle_end && normalized) begin
               cycle_next = exp_ovf ? fcd_pkg::CY_INTR :
                  (op_reg == fcd_pkg::OP_STORE) ? fcd_pkg::CY_WRITE :
                  fcd_pkg::CY_IDLE;
            end
         end
         fcd_pkg::CY_WRITE: begin
            if (cycle_end && (word_count_reg == need_words - 2'h1))
               cycle_next = fcd_pkg::CY_IDLE;
         end
         fcd_pkg::CY_INTR: if (cycle_end) cycle_next = fcd_pkg::CY_IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // sequencer and timing counters
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         cycle_reg <= fcd_pkg::CY_IDLE;
         tick_reg <= 2'h0;
         phase_reg <= 4'h0;
      end else begin
         cycle_reg <= cycle_next;
         // every cycle starts on a phase boundary, so none loses part of its first phase
         tick_reg <= (phase_en || cycle_next != cycle_reg) ? 2'h0 :
            tick_reg + 2'h1;
         if (cycle_next != cycle_reg) phase_reg <= 4'h0;
         else if (cycle_end) phase_reg <= 4'h0;
         else if (phase_en) phase_reg <= phase_reg + 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // pin synchronisers for the memory bus
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         mem_half_s1 <= 18'h00000;
         mem_half_s2 <= 18'h00000;
         mem_valid_s1 <= 1'b0;
         mem_valid_s2 <= 1'b0;
      end else begin
         mem_half_s1 <= i_MEM_HALF;
         mem_half_s2 <= mem_half_s1;
         mem_valid_s1 <= i_MEM_VALID;
         mem_valid_s2 <= mem_valid_s1;
      end
   end

   // -----------------------------------------------------------------
   // memory word buffer, instruction latch, address, trap vector
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         memory_word_buffer_reg <= 36'h000000000;
         half_sel_reg <= 1'b0;
         instruction_latch_reg <= 12'h000;
         operand_address_reg <= 17'h00000;
         trap_vector_base_reg <= 15'h0000;
         indirect_reg <= 1'b0;
         fmt_reg <= 2'h0;
         op_reg <= 3'h0;
         nonmem_reg <= 1'b0;
         round_reg <= 1'b0;
      end else begin
         if (i_TRAP_LOAD) trap_vector_base_reg <= i_TRAP_DATA;
         if (cycle_reg == fcd_pkg::CY_IDLE && i_START) begin
            fmt_reg <= i_FMT;
            op_reg <= i_OP;
            nonmem_reg <= i_NONMEM;
            round_reg <= i_ROUND;
            half_sel_reg <= 1'b0;
         end
         // high half first, then low half completes the word
         if (mem_valid_s2) begin
            half_sel_reg <= !half_sel_reg;
            if (!half_sel_reg)
               memory_word_buffer_reg[35:18] <= mem_half_s2;
            else memory_word_buffer_reg[17:0] <= mem_half_s2;
         end
         if (word_in && cycle_reg == fcd_pkg::CY_FETCH) begin
            if (!indirect_reg) begin
               instruction_latch_reg <= mem_word[17:6];
               indirect_reg <= mem_word[17];
            end else indirect_reg <= 1'b0;
            operand_address_reg <= mem_word[16:0];
         end else if (word_in && cycle_reg == fcd_pkg::CY_OPAND) begin
            operand_address_reg <= operand_address_reg + 17'h00001;
         end else if (cycle_reg == fcd_pkg::CY_WRITE && cycle_end) begin
            operand_address_reg <= operand_address_reg + 17'h00001;
         end
      end
   end

   // -----------------------------------------------------------------
   // exponents, mantissas, extension, shift counter
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         acc_exponent_counter_reg <= 18'h00000;
         operand_exponent_reg <= 18'h00000;
         acc_mantissa_reg <= 35'h000000000;
         acc_sign_reg <= 1'b0;
         operand_mantissa_reg <= 35'h000000000;
         operand_sign_reg <= 1'b0;
         mantissa_extension_reg <= 36'h000000000;
         shift_count_reg <= fcd_pkg::SHIFT_RST;
         word_count_reg <= 2'h0;
      end else begin
         if (cycle_next != cycle_reg) shift_count_reg <= fcd_pkg::SHIFT_RST;
         if (cycle_reg == fcd_pkg::CY_FETCH ||
            cycle_reg == fcd_pkg::CY_JUSTIFY) word_count_reg <= 2'h0;
         unique case (cycle_reg)
            fcd_pkg::CY_OPAND: if (word_in) begin
               word_count_reg <= word_count_reg + 2'h1;
               if (word_count_reg == 2'h0 && is_float) begin
                  // single precision: sign bit 9 extends down to bit 0
                  operand_exponent_reg <= (fmt_reg == fcd_pkg::FMT_SPF) ?
                     {mem_word[17:10], {10{sp_exp_neg}}} :
                     mem_word[17:0];
                  operand_sign_reg <= mem_word[35];
                  operand_mantissa_reg[34:18] <= mem_word[34:18];
               end else begin
                  operand_sign_reg <= is_float ? operand_sign_reg :
                     mem_word[35];
                  operand_mantissa_reg <= mem_word[34:0];
               end
            end
            fcd_pkg::CY_SCALE: begin
               if (!is_float && operand_sign_reg && phase_reg == 4'h0
                  && phase_en) operand_mantissa_reg <=
                     35'(-operand_mantissa_reg);
               if (is_muldiv && cycle_end) begin
                  acc_exponent_counter_reg <= (op_reg == fcd_pkg::OP_MUL)
                     ? acc_exponent_counter_reg + operand_exponent_reg
                     : exp_diff;
               end
               if (is_float && is_addsub && !aligned && exp_too_far) begin
                  shift_count_reg <= fcd_pkg::MAX_SHIFT;
               end else if (is_float && is_addsub && !aligned && shift_en)
               begin
                  shift_count_reg <= shift_count_reg + 6'h01;
                  // shifted-out bits fall into the extension
                  if (exp_acc_small) begin
                     acc_mantissa_reg <= {1'b0, acc_mantissa_reg[34:1]};
                     acc_exponent_counter_reg <=
                        acc_exponent_counter_reg + 18'h00001;
                  end else begin
                     operand_mantissa_reg <=
                        {1'b0, operand_mantissa_reg[34:1]};
                     operand_exponent_reg <=
                        operand_exponent_reg + 18'h00001;
                  end
                  mantissa_extension_reg <= {exp_acc_small ?
                     acc_mantissa_reg[0] : operand_mantissa_reg[0],
                     mantissa_extension_reg[35:1]};
               end
            end
            fcd_pkg::CY_COMPUTE: begin
               if (is_muldiv && !muldiv_done && shift_en) begin
                  shift_count_reg <= shift_count_reg + 6'h01;
                  // load while shifting: add-shift step of multiply
                  {acc_mantissa_reg, mantissa_extension_reg[35]} <=
                     mantissa_extension_reg[0] ?
                     {alu_sum[35:0]} : {1'b0, acc_mantissa_reg};
                  mantissa_extension_reg[34:0] <=
                     mantissa_extension_reg[35:1];
                  acc_sign_reg <= acc_sign_reg ^ operand_sign_reg;
               end else if (!is_muldiv && cycle_end) begin
                  acc_mantissa_reg <= alu_bus[34:0];
                  acc_sign_reg <= (eff_sub && alu_diff[35]) ?
                     !acc_sign_reg : acc_sign_reg;
               end
            end
            fcd_pkg::CY_JUSTIFY: begin
               if (!normalized && shift_en) begin
                  shift_count_reg <= shift_count_reg + 6'h01;
                  acc_mantissa_reg <= {acc_mantissa_reg[33:0],
                     mantissa_extension_reg[35]};
                  mantissa_extension_reg <=
                     {mantissa_extension_reg[34:0], 1'b0};
                  acc_exponent_counter_reg <=
                     acc_exponent_counter_reg - 18'h00001;
               end else if (normalized && cycle_end && round_reg &&
                  mantissa_extension_reg[35]) begin
                  acc_mantissa_reg <= acc_mantissa_reg + 35'h000000001;
                  mantissa_extension_reg <= 36'h000000000;
               end
            end
            fcd_pkg::CY_WRITE: if (cycle_end)
               word_count_reg <= word_count_reg + 2'h1;
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // error flag: set on divide by zero or exponent overflow
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) error_reg <= 1'b0;
      else if (cycle_next == fcd_pkg::CY_INTR) error_reg <= 1'b1;
      else if (i_START) error_reg <= 1'b0;
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // fetch and operand load request words; write drives the store data
   assign o_MEM_REQ = (cycle_reg == fcd_pkg::CY_FETCH) ||
      (cycle_reg == fcd_pkg::CY_OPAND) || (cycle_reg == fcd_pkg::CY_WRITE);
   assign o_MEM_WRITE = (cycle_reg == fcd_pkg::CY_WRITE);
   assign o_MEM_ADDR = operand_address_reg;
   assign o_MEM_WDATA = (word_count_reg == 2'h0) ?
      acc_exponent_counter_reg : {acc_sign_reg, acc_mantissa_reg[34:18]};
   assign o_CYCLE = cycle_reg;
   assign o_BUSY = (cycle_reg != fcd_pkg::CY_IDLE);
   assign o_ERROR = error_reg;
   assign o_TRAP_VECTOR = trap_vector_base_reg;
   assign o_INSTR = instruction_latch_reg;
   assign o_ACC_EXP = acc_exponent_counter_reg;
   assign o_ACC_SIGN = acc_sign_reg;
   assign o_ACC_MANT = acc_mantissa_reg;
endmodule
`default_nettype wire

// [shared/fcd_pkg.sv]
// constants and types for the floating unit cycle datapath
package fcd_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int PHASE_NS = 75;
   localparam int STATE_NS = 300;
   localparam int CYCLE_NS = 900;
   localparam int NORM_SHIFT_NS = 150;
   localparam int WORD_NS = 1200;
   // 50 ns does not divide 75 ns; least time rounds up
   localparam int PHASE_CLKS = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PHASES_PER_STATE = STATE_NS / PHASE_NS;
   localparam int STATES_PER_CYCLE = CYCLE_NS / STATE_NS;
   localparam int PHASES_PER_CYCLE = PHASES_PER_STATE * STATES_PER_CYCLE;
   localparam int NORM_SHIFT_CLKS = (NORM_SHIFT_NS + CLK_NS - 1) / CLK_NS;
   localparam int WORD_CYCLES = (WORD_NS + CYCLE_NS - 1) / CYCLE_NS;
   // -----------------------------------------------------------------
   // widths and fields
   // -----------------------------------------------------------------
   localparam int WORD_W = 36;
   localparam int HALF_W = 18;
   localparam int INSTR_W = 12;
   localparam int INSTR_LO = 6;
   localparam int ADDR_W = 17;
   localparam int EXP_W = 18;
   localparam int MANT_W = 35;
   localparam int TRAP_W = 15;
   localparam int SP_EXP_MSB = 9;
   localparam logic [5:0] MAX_SHIFT = 6'h23;
   localparam logic [5:0] SHIFT_RST = 6'h00;
   // -----------------------------------------------------------------
   // operation and format codes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_SPI = 2'h0, FMT_DPI = 2'h1, FMT_SPF = 2'h2, FMT_DPF = 2'h3
   } fcd_fmt_t;
   typedef enum logic [2:0] {
      OP_ADD = 3'h0, OP_SUB = 3'h1, OP_MUL = 3'h2, OP_DIV = 3'h3,
      OP_LOAD = 3'h4, OP_NEG = 3'h5, OP_CLR = 3'h6, OP_STORE = 3'h7
   } fcd_op_t;
   typedef enum logic [2:0] {
      CY_IDLE = 3'h0, CY_FETCH = 3'h1, CY_OPAND = 3'h2, CY_SCALE = 3'h3,
      CY_COMPUTE = 3'h4, CY_JUSTIFY = 3'h5, CY_WRITE = 3'h6, CY_INTR = 3'h7
   } fcd_cycle_t;
   // number of operand words per format
   function automatic logic [1:0] words_of(input logic [1:0] fmt);
      logic [1:0] w;
      w = 2'h1;
      unique case (fmt)
         FMT_SPI: w = 2'h1;
         FMT_DPI: w = 2'h2;
         FMT_SPF: w = 2'h2;
         FMT_DPF: w = 2'h3;
      endcase
      return w;
   endfunction
endpackage

// [testbench/fcd_datapath_monitor.sv]
// assertion checker on the ports of the floating unit datapath
`timescale 1ns/100ps
`default_nettype none
module fcd_datapath_monitor (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic i_START,
   input wire logic i_TRAP_LOAD,
   input wire logic [14:0] i_TRAP_DATA,
   input wire logic o_MEM_REQ,
   input wire logic o_MEM_WRITE,
   input wire logic [2:0] o_CYCLE,
   input wire logic o_BUSY,
   input wire logic [14:0] o_TRAP_VECTOR,
   input wire logic [11:0] o_INSTR
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   // ---------------------------------------------------------------
   // cycle length tracker
   // ---------------------------------------------------------------
   logic [2:0] prev_reg;
   logic [7:0] len_reg;
   logic [7:0] len_next;
   wire changed_w = o_CYCLE != prev_reg;
   wire timed_w = prev_reg inside {3'h3, 3'h4, 3'h5, 3'h7};
   // saturates so that a hung cycle never wraps under the limit
   assign len_next = (len_reg == 8'hFF) ? len_reg : len_reg + 8'h01;
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         prev_reg <= 3'h0;
         len_reg <= 8'h00;
      end else begin
         prev_reg <= o_CYCLE;
         len_reg <= changed_w ? 8'h01 : len_next;
      end
   end
   // codes: 0 idle 1 fetch 2 load 3 scale 4 compute 5 justify 6 write 7 intr
   a_req_cycle: assert property (o_MEM_REQ == (o_CYCLE inside {3'h1, 3'h2, 3'h6}))
      else $error("memory request outside a memory cycle");
   a_write_cycle: assert property (o_MEM_WRITE == (o_CYCLE == 3'h6))
      else $error("write strobe outside the write cycle");
   a_busy_cycle: assert property (o_BUSY == (o_CYCLE != 3'h0))
      else $error("busy does not match cycle code");
   a_start_fetch: assert property (o_CYCLE == 3'h0 && i_START |=> o_CYCLE == 3'h1)
      else $error("start did not enter fetch");
   a_start_refused: assert property (o_CYCLE > 3'h1 && i_START |=> o_CYCLE != 3'h1)
      else $error("start taken while busy");
   a_cycle_order: assert property ($changed(o_CYCLE) |-> o_CYCLE == 3'h7 ||
      o_CYCLE == $past(o_CYCLE) + 3'h1 || ($past(o_CYCLE) == 3'h1 && o_CYCLE == 3'h3)
      || (o_CYCLE == 3'h0 && $past(o_CYCLE) inside {3'h5, 3'h6}))
      else $error("illegal cycle succession");
   // an interrupt may cut a cycle short, so it is left out here
   a_basic_len: assert property (changed_w && timed_w && o_CYCLE != 3'h7 |-> len_reg >= 8'h18)
      else $error("cycle shorter than a basic cycle");
   a_trap_load: assert property (i_TRAP_LOAD |=> o_TRAP_VECTOR == $past(i_TRAP_DATA))
      else $error("trap vector not loaded");
   a_instr_hold: assert property ($changed(o_INSTR) |-> $past(o_CYCLE) == 3'h1 || $past(o_CYCLE, 2) == 3'h1)
      else $error("instruction latch changed outside fetch");
endmodule
bind fcd_datapath fcd_datapath_monitor u_mon (.I_CLK, .I_RESETN, .i_START,
   .i_TRAP_LOAD, .i_TRAP_DATA, .o_MEM_REQ, .o_MEM_WRITE, .o_CYCLE, .o_BUSY,
   .o_TRAP_VECTOR, .o_INSTR);
`default_nettype wire

// [testbench/fcd_mem_model.sv]
// host memory bus model that serves queued words in half words
`timescale 1ns/100ps
`default_nettype none
module fcd_mem_model (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic i_slow,
   output logic [17:0] o_half,
   output logic o_valid
);
   logic [35:0] words[$];
   logic [35:0] w;
   int served;
   initial begin
      o_half = 18'h0;
      o_valid = 1'b0;
      served = 0;
   end
   // released lines show the inverse, so a stale value is never mistaken
   task automatic give(input logic [17:0] h);
      o_half <= h;
      o_valid <= 1'b1;
      @(posedge i_clk);
      o_half <= ~h;
      o_valid <= 1'b0;
   endtask
   // high half first, one idle cycle between halves
   always begin
      @(posedge i_clk);
      if (i_req && !i_write && words.size() > 0) begin
         w = words.pop_front();
         give(w[35:18]);
         @(posedge i_clk);
         give(w[17:0]);
         served++;
         // pause lets the synced word land before the next request is seen
         repeat (i_slow ? 20 : 8) @(posedge i_clk);
      end
   end
endmodule
`default_nettype wire

// [testbench/fcd_datapath_bench.sv]
// self-checking bench for the floating unit cycle datapath
`timescale 1ns/100ps
`default_nettype none
module fcd_datapath_bench;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, nonmem = 1'b0, rnd = 1'b0;
   logic tload = 1'b0, slow = 1'b0, valid, req, wr, busy, err, asign;
   logic [1:0] fmt = 2'h0;
   logic [2:0] op = 3'h0, cyc;
   logic [14:0] tdata = 15'h0, tvec;
   logic [17:0] half, wdata, aexp;
   logic [16:0] addr, op_addr;
   logic [11:0] instr;
   logic [34:0] amant;
   logic [31:0] trace;
   int num_errors = 0, checks_done = 0, fe_w, op_w, wr_cnt, intr_cnt, n;
   always #25 clk = ~clk;
   fcd_datapath dut (.I_CLK(clk), .I_RESETN(rst_n), .i_START(start),
      .i_NONMEM(nonmem), .i_FMT(fmt), .i_OP(op), .i_ROUND(rnd),
      .i_MEM_HALF(half), .i_MEM_VALID(valid), .i_TRAP_LOAD(tload),
      .i_TRAP_DATA(tdata), .o_MEM_REQ(req), .o_MEM_WRITE(wr),
      .o_MEM_ADDR(addr), .o_MEM_WDATA(wdata), .o_CYCLE(cyc), .o_BUSY(busy),
      .o_ERROR(err), .o_TRAP_VECTOR(tvec), .o_INSTR(instr), .o_ACC_EXP(aexp),
      .o_ACC_SIGN(asign), .o_ACC_MANT(amant));
   fcd_mem_model mem (.i_clk(clk), .i_req(req), .i_write(wr),
      .i_slow(slow), .o_half(half), .o_valid(valid));
   task automatic summarize();
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [35:0] e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // instruction word, then k operand words
   task automatic feed(input logic [35:0] iw, input int k, input logic [35:0] ow);
      mem.words.delete();
      mem.words.push_back(iw);
      repeat (k) mem.words.push_back(ow);
   endtask
   // one instruction; records cycle trace, words per cycle, write time
   task automatic run(input logic [1:0] f, input logic [2:0] o, input logic nm);
      int s0;
      logic [2:0] last;
      logic hit;
      trace = 0; wr_cnt = 0; intr_cnt = 0; op_w = 0; fe_w = 0;
      s0 = mem.served;
      last = 3'h0;
      hit = 1'b0;
      @(posedge clk);
      start <= 1'b1; fmt <= f; op <= o; nonmem <= nm;
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 4000; n++) begin
         @(posedge clk);
         start <= hit;
         hit = 1'b0;
         #1;
         wr_cnt += int'(wr === 1'b1);
         intr_cnt += int'(cyc === 3'h7);
         if (cyc !== last) begin
            trace = {trace[27:0], 1'b0, cyc};
            if (cyc === 3'h2) begin
               fe_w = mem.served - s0;
               op_addr = addr;
            end
            if (last === 3'h2) op_w = mem.served - s0 - fe_w;
            // a start in mid-instruction must be refused
            if (cyc === 3'h4) hit = 1'b1;
            last = cyc;
         end
         if (cyc === 3'h0) break;
      end
      if (n == 4000) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic t_reset();
      check("cycle", 0, cyc);
      check("instr", 0, instr);
      check("mantissa", 0, amant);
   endtask
   task automatic t_trap();
      @(posedge clk);
      tload <= 1'b1; tdata <= 15'h5A5A;
      @(posedge clk);
      tdata <= 15'h25A5;
      @(posedge clk);
      tload <= 1'b0;
      #1 check("trap", 15'h25A5, tvec);
   endtask
   task automatic t_formats();
      int exp_w[4] = '{1, 2, 2, 3};
      logic [35:0] iw;
      for (int f = 0; f < 4; f++) begin
         iw = {16'h1234, f[1:0], 18'h05A5C + 18'(f)};
         feed(iw, exp_w[f], 36'h200000003);
         run(f[1:0], 3'h0, 1'b0);
         check("order", 32'h123450, trace);
         check("words", exp_w[f], op_w);
         check("instr", iw[17:6], instr);
         check("address", iw[16:0], op_addr);
         check("sign", 1'b0, asign);
      end
   endtask
   task automatic t_nonmem();
      feed(36'h000000400, 0, 36'h0);
      run(2'h3, 3'h5, 1'b1);
      check("order", 32'h13450, trace);
      check("normalized", 1'b1, amant[34]);
   endtask
   task automatic t_indirect();
      slow = 1'b1;
      feed(36'h000020FC0, 1, 36'h1);
      mem.words.insert(1, 36'h000000CCC);
      run(2'h0, 3'h0, 1'b0);
      slow = 1'b0;
      check("fetch words", 2, fe_w);
      check("address", 17'h00CCC, op_addr);
      check("instr", 12'h83F, instr);
   endtask
   task automatic t_store();
      for (int k = 1; k < 3; k++) begin
         feed(36'h000000200, k, 36'h3);
         run(k[1:0] - 2'h1, 3'h7, 1'b0);
         check("order", 32'h1234560, trace);
         check("write time", 24 * k, wr_cnt);
      end
   endtask
   task automatic t_divzero();
      feed(36'h000000100, 2, 36'h0);
      run(2'h2, 3'h3, 1'b0);
      check("intr time", 24, intr_cnt);
      check("error", 1'b1, err);
      feed(36'h000000100, 1, 36'h5);
      run(2'h0, 3'h0, 1'b0);
      check("error clear", 1'b0, err);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1 t_reset();
      t_trap();
      t_formats();
      t_nonmem();
      t_indirect();
      t_store();
      t_divzero();
      summarize();
   end
endmodule
`default_nettype wire
